// ==== rtv_pkg.sv ====
package rtv_pkg;
	localparam logic [11:0] TIME_OFFSET = 12'h000;
	localparam logic [11:0] CTRL_OFFSET = 12'h004;
	localparam int HOUR_TENS_LSB = 28;
	localparam int HOUR_UNITS_LSB = 24;
	localparam int MIN_TENS_LSB = 20;
	localparam int MIN_UNITS_LSB = 16;
	localparam int SEC_TENS_LSB = 12;
	localparam int SEC_UNITS_LSB = 8;
	localparam int UNLOCK_BIT = 3;
	localparam logic [3:0] HOUR_TENS_MAX = 4'h2;
	localparam logic [3:0] UNITS_MAX = 4'h9;
	localparam logic [3:0] SIX_TENS_MAX = 4'h5;
	localparam logic [23:0] TIME_RESET = 24'h000000;
endpackage

// ==== rtv_time_reg.sv ====
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
// Function
// - hour tens digit, bits 31-28, 0..2
// - hour units digit, bits 27-24, 0..9
// - minute tens digit, bits 23-20, 0..5
// - minute units digit, bits 19-16, 0..9
// - second tens digit, bits 15-12, 0..5
// - second units digit, bits 11-8, 0..9
// - low byte reads zero, ignores writes
// - time writes only while unlock bit set
module rtv_time_reg (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [3:0] hourTensDigit,
	output logic [3:0] hourUnitsDigit,
	output logic [3:0] minuteTensDigit,
	output logic [3:0] minuteUnitsDigit,
	output logic [3:0] secondTensDigit,
	output logic [3:0] secondUnitsDigit,
	output logic clockWriteUnlock
);
	logic [23:0] time_q;
	logic unlock_q;
	logic [31:0] prdata_q;
	logic wrEn;
	logic rdEn;
	logic hitTime;
	logic hitCtrl;

	function automatic logic [3:0] clampDigit(input logic [3:0] v,
			input logic [3:0] maxV);
		clampDigit = (v > maxV) ? maxV : v;
	endfunction

	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign hitTime = (paddr == rtv_pkg::TIME_OFFSET);
	assign hitCtrl = (paddr == rtv_pkg::CTRL_OFFSET);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hitTime && !hitCtrl;

	// control word: write unlock
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			unlock_q <= 1'b0;
		end else if (wrEn && hitCtrl && pstrb[0]) begin
			unlock_q <= pwdata[rtv_pkg::UNLOCK_BIT];
		end
	end

	// time digits; reset loads TIME_RESET (all digits zero)
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			time_q <= rtv_pkg::TIME_RESET;
		end else if (wrEn && hitTime && unlock_q) begin
			if (pstrb[3]) begin
				time_q[23:20] <= clampDigit(
					pwdata[rtv_pkg::HOUR_TENS_LSB +: 4],
					rtv_pkg::HOUR_TENS_MAX);
				time_q[19:16] <= clampDigit(
					pwdata[rtv_pkg::HOUR_UNITS_LSB +: 4],
					rtv_pkg::UNITS_MAX);
			end
			if (pstrb[2]) begin
				time_q[15:12] <= clampDigit(
					pwdata[rtv_pkg::MIN_TENS_LSB +: 4],
					rtv_pkg::SIX_TENS_MAX);
				time_q[11:8] <= clampDigit(
					pwdata[rtv_pkg::MIN_UNITS_LSB +: 4],
					rtv_pkg::UNITS_MAX);
			end
			if (pstrb[1]) begin
				time_q[7:4] <= clampDigit(
					pwdata[rtv_pkg::SEC_TENS_LSB +: 4],
					rtv_pkg::SIX_TENS_MAX);
				time_q[3:0] <= clampDigit(
					pwdata[rtv_pkg::SEC_UNITS_LSB +: 4],
					rtv_pkg::UNITS_MAX);
			end
		end
	end

	// read data registered at setup
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == rtv_pkg::TIME_OFFSET) begin
				prdata_q <= {time_q, 8'h00};
			end else if (paddr == rtv_pkg::CTRL_OFFSET) begin
				prdata_q <= 32'h00000000 |
					(32'(unlock_q) << rtv_pkg::UNLOCK_BIT);
			end else begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	assign prdata = rdEn ? prdata_q : 32'h00000000;
	assign hourTensDigit = time_q[23:20];
	assign hourUnitsDigit = time_q[19:16];
	assign minuteTensDigit = time_q[15:12];
	assign minuteUnitsDigit = time_q[11:8];
	assign secondTensDigit = time_q[7:4];
	assign secondUnitsDigit = time_q[3:0];
	assign clockWriteUnlock = unlock_q;
endmodule

// ==== rtv_time_reg_assertions.sv ====
`timescale 1ns/100ps
module rtv_time_reg_chk (
	input wire logic core_clk, rst_n, psel, penable, pwrite, clockWriteUnlock,
	input wire logic [11:0] paddr,
	input wire logic [3:0] pstrb, hourTensDigit, hourUnitsDigit,
	input wire logic [3:0] minuteTensDigit, minuteUnitsDigit,
	input wire logic [3:0] secondTensDigit, secondUnitsDigit,
	input wire logic [31:0] pwdata, prdata
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire logic [23:0] timeVal = {hourTensDigit, hourUnitsDigit,
		minuteTensDigit, minuteUnitsDigit, secondTensDigit, secondUnitsDigit};
	wire logic tA = psel && penable && paddr == 12'h000;
	property p_hr; hourTensDigit <= 4'h2 && hourUnitsDigit <= 4'h9; endproperty
	a_hr: assert property (p_hr) else $error("hour digit range");
	property p_mn; minuteTensDigit <= 4'h5 && minuteUnitsDigit <= 4'h9; endproperty
	a_mn: assert property (p_mn) else $error("minute digit range");
	property p_sc; secondTensDigit <= 4'h5 && secondUnitsDigit <= 4'h9; endproperty
	a_sc: assert property (p_sc) else $error("second digit range");
	property p_rd; tA && !pwrite |-> prdata == {timeVal, 8'h00}; endproperty
	a_rd: assert property (p_rd) else $error("time read mapping");
	property p_wr; tA && pwrite && clockWriteUnlock && pstrb[1] &&
		pwdata[11:8] < 4'ha |=> secondUnitsDigit == $past(pwdata[11:8]); endproperty
	a_wr: assert property (p_wr) else $error("unlocked write lost");
	property p_lk; tA && pwrite && !clockWriteUnlock |=> $stable(timeVal); endproperty
	a_lk: assert property (p_lk) else $error("locked write taken");
endmodule
bind rtv_time_reg rtv_time_reg_chk u_chk (.*);

// ==== rtv_time_reg_test.sv ====
`timescale 1ns/100ps
module rtv_time_reg_test;
	logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 0, hourTensDigit, hourUnitsDigit, minuteTensDigit;
	logic [3:0] minuteUnitsDigit, secondTensDigit, secondUnitsDigit;
	logic pready, pslverr, clockWriteUnlock, ok, err;
	int n_fail = 0, checks_done = 0;
	always #25 core_clk = ~core_clk;
	rtv_time_reg u_dut (.*);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
		@(posedge core_clk);
		penable <= 1;
		for (i = 0, ok = 0; i < 9 && ok !== 1'b1; i++) begin
			@(posedge core_clk);
			ok = pready;
			rd = prdata;
			err = pslverr;
		end
		psel <= 0;
		penable <= 0;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("[ERR] %0t no ready", $time);
			complete_run();
		end
		@(posedge core_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		xfer(0, a, 0);
		chk(rd, e);
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1;
		xfer(1, 12'h000, 32'h12345678);
		rc(12'h000, 32'h0);
		xfer(1, 12'h004, 32'h8);
		rc(12'h004, 32'h8);
		chk(32'(clockWriteUnlock), 32'h1);
		xfer(1, 12'h000, 32'h23595978);
		rc(12'h000, 32'h23595900);
		chk({8'h00, hourTensDigit, hourUnitsDigit, minuteTensDigit,
			minuteUnitsDigit, secondTensDigit, secondUnitsDigit},
			32'h00235959);
		xfer(1, 12'h000, 32'hffffffff);
		rc(12'h000, 32'h29595900);
		xfer(1, 12'h004, 32'h0);
		xfer(1, 12'h000, 32'h01020300);
		rc(12'h000, 32'h29595900);
		rc(12'h008, 32'h0);
		chk(32'(err), 32'h1);
		$display("register sequence done");
		complete_run();
	end
endmodule
